// ===== hdl/srw_reset_wdt.sv
`timescale 1ns/1ps
`include "srw_cfg.svh"
module srw_reset_watch #(
   parameter bit LVR_EN = 1'b1,
   parameter bit WATCH_EN = 1'b1,
   parameter int WATCH_TICKS = `SRW_WATCH_TICKS
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // reset sources
   input wire logic extResetPin_n,
   input wire logic supplyLow,
   input wire logic wakeEvent,
   // watchdog time base
   input wire logic lfTick,
   input wire logic prescTick,
   // wishbone slave
   input wire srw_pkg::srw_wb_req_t wbReq,
   output srw_pkg::srw_wb_rsp_t wbRsp,
   // system reset
   output logic sysReset
);
   // ***********************
   // state
   // ***********************
   srw_pkg::srw_state_t s_q;
   srw_pkg::srw_state_t s_d;
   logic access;
   logic clearWr;
   logic statusWr;
   logic statusRd;
   logic lvrHit;
   logic tick;
   logic expire;
   logic srcHit;

   always_comb begin
      access = wbReq.cyc & wbReq.stb & ~s_q.ack;
      clearWr = access & wbReq.we & (wbReq.adr == `SRW_WATCH_CLEAR_ADDR); // RULE7
      statusWr = access & wbReq.we & (wbReq.adr == `SRW_STATUS_ADDR);
      statusRd = access & ~wbReq.we & (wbReq.adr == `SRW_STATUS_ADDR);
      lvrHit = LVR_EN & supplyLow; // RULE3 RULE4
      tick = lfTick | prescTick; // RULE8
      expire = WATCH_EN & ~s_q.sysRst & ~clearWr & tick
         & (s_q.watchCnt == 16'(WATCH_TICKS - 1)); // RULE5
      srcHit = ~extResetPin_n | lvrHit | wakeEvent; // RULE1
      s_d = s_q;
      s_d.ack = access;
      s_d.rdat = 8'h00;
      if (statusRd) begin
         s_d.rdat = {7'h00, s_q.causeWatch};
      end
      if (s_q.porCnt != 5'h00) begin
         s_d.porCnt = s_q.porCnt - 5'h01; // RULE2
      end
      if (wakeEvent) begin
         s_d.wakeCnt = 3'(`SRW_WAKE_CYCLES); // RULE9
      end else if (s_q.wakeCnt != 3'h0) begin
         s_d.wakeCnt = s_q.wakeCnt - 3'h1;
      end
      if (s_q.sysRst || clearWr) begin
         s_d.watchCnt = 16'h0000; // RULE7 RULE10
      end else if (WATCH_EN && tick) begin
         s_d.watchCnt = s_q.watchCnt + 16'h0001; // RULE8
      end
      s_d.sysRst = srcHit | (s_q.porCnt != 5'h00)
         | (s_q.wakeCnt != 3'h0) | expire; // RULE10
      // hardware set wins over a software clear in the same cycle
      if (statusWr) begin
         s_d.causeWatch = 1'b0;
      end
      if (expire) begin
         s_d.causeWatch = 1'b1; // RULE5
      end
   end

   // ***********************
   // registers
   // ***********************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{watchCnt: 16'h0000, porCnt: 5'(`SRW_POR_CYCLES), wakeCnt: 3'h0,
                  sysRst: 1'b1, ack: 1'b0, rdat: 8'h00, causeWatch: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // ***********************
   // outputs
   // ***********************
   always_comb begin
      sysReset = s_q.sysRst;
      wbRsp.ack = s_q.ack;
      wbRsp.dat = s_q.rdat;
   end

   // ***********************
   // checks: reset sources
   // ***********************
   a_pin_reset: assert property ( // RULE1
      @(posedge clk_sys) disable iff (!rst_n)
      !extResetPin_n |=> sysReset)
      else $error("pin low without reset");

   a_pin_hold: assert property ( // RULE1
      @(posedge clk_sys) disable iff (!rst_n)
      !extResetPin_n ##1 !extResetPin_n |=> sysReset)
      else $error("pin held without reset");

   a_lvr_reset: assert property ( // RULE4
      @(posedge clk_sys) disable iff (!rst_n)
      (LVR_EN && supplyLow) |=> sysReset)
      else $error("low supply without reset");

   a_lvr_off: assert property ( // RULE3
      @(posedge clk_sys) disable iff (!rst_n)
      (!LVR_EN && supplyLow && extResetPin_n && !wakeEvent && s_q.porCnt == 5'h00
       && s_q.wakeCnt == 3'h0 && !expire) |=> !sysReset)
      else $error("low supply reset with option off");

   a_quiet_run: assert property ( // RULE10
      @(posedge clk_sys) disable iff (!rst_n)
      (extResetPin_n && !lvrHit && !wakeEvent && s_q.porCnt == 5'h00
       && s_q.wakeCnt == 3'h0 && !expire) |=> !sysReset)
      else $error("reset without source");

   a_any_source: assert property ( // RULE10
      @(posedge clk_sys) disable iff (!rst_n)
      (srcHit || expire) |=> sysReset)
      else $error("source without reset");

   // ***********************
   // checks: power-on stretch
   // ***********************
   a_por_hold: assert property ( // RULE2
      @(posedge clk_sys)
      $rose(rst_n) |-> sysReset [*8])
      else $error("no power-on reset");

   a_por_load: assert property ( // RULE2
      @(posedge clk_sys)
      $rose(rst_n) |-> s_q.porCnt == 5'(`SRW_POR_CYCLES))
      else $error("power-on count not loaded");

   a_por_count: assert property ( // RULE2
      @(posedge clk_sys) disable iff (!rst_n)
      s_q.porCnt != 5'h00 |=> sysReset)
      else $error("power-on stretch without reset");

   a_por_step: assert property ( // RULE2
      @(posedge clk_sys) disable iff (!rst_n)
      s_q.porCnt != 5'h00 |=> s_q.porCnt == $past(s_q.porCnt) - 5'h01)
      else $error("power-on count skipped");

   a_por_done: assert property ( // RULE2
      @(posedge clk_sys) disable iff (!rst_n)
      s_q.porCnt == 5'h00 |=> s_q.porCnt == 5'h00)
      else $error("power-on count restarted");

   // ***********************
   // checks: wake-up
   // ***********************
   a_wake_reset: assert property ( // RULE9
      @(posedge clk_sys) disable iff (!rst_n)
      wakeEvent |=> sysReset [*5])
      else $error("wake without reset");

   a_wake_load: assert property ( // RULE9
      @(posedge clk_sys) disable iff (!rst_n)
      wakeEvent |=> s_q.wakeCnt == 3'(`SRW_WAKE_CYCLES))
      else $error("wake count not loaded");

   a_wake_step: assert property ( // RULE9
      @(posedge clk_sys) disable iff (!rst_n)
      (!wakeEvent && s_q.wakeCnt != 3'h0) |=> s_q.wakeCnt == $past(s_q.wakeCnt) - 3'h1)
      else $error("wake count skipped");

   a_wake_hold: assert property ( // RULE9
      @(posedge clk_sys) disable iff (!rst_n)
      s_q.wakeCnt != 3'h0 |=> sysReset)
      else $error("wake stretch without reset");

   // ***********************
   // checks: watchdog
   // ***********************
   a_watch_clear: assert property ( // RULE7
      @(posedge clk_sys) disable iff (!rst_n)
      clearWr |=> s_q.watchCnt == 16'h0000)
      else $error("clear ignored");

   a_watch_freeze: assert property ( // RULE8
      @(posedge clk_sys) disable iff (!rst_n)
      (!tick && !clearWr && !s_q.sysRst) |=> $stable(s_q.watchCnt))
      else $error("count moved");

   a_watch_step: assert property ( // RULE8
      @(posedge clk_sys) disable iff (!rst_n)
      (WATCH_EN && tick && !clearWr && !s_q.sysRst)
      |=> s_q.watchCnt == $past(s_q.watchCnt) + 16'h0001)
      else $error("tick not counted");

   a_watch_off: assert property ( // RULE5
      @(posedge clk_sys) disable iff (!rst_n)
      !WATCH_EN |-> s_q.watchCnt == 16'h0000)
      else $error("disabled watchdog counts");

   a_watch_expire: assert property ( // RULE5
      @(posedge clk_sys) disable iff (!rst_n)
      (WATCH_EN && tick && !clearWr && !s_q.sysRst
       && s_q.watchCnt == 16'(WATCH_TICKS - 1))
      |=> sysReset ##1 s_q.watchCnt == 16'h0000)
      else $error("no watchdog reset");

   a_watch_bound: assert property ( // RULE5
      @(posedge clk_sys) disable iff (!rst_n)
      s_q.watchCnt <= 16'(WATCH_TICKS))
      else $error("count past interval");

   a_expire_once: assert property ( // RULE5
      @(posedge clk_sys) disable iff (!rst_n)
      expire |=> !expire)
      else $error("watchdog fired twice");

   a_rst_clears: assert property ( // RULE10
      @(posedge clk_sys) disable iff (!rst_n)
      sysReset |=> s_q.watchCnt == 16'h0000)
      else $error("count kept in reset");

   // ***********************
   // checks: cause flag
   // ***********************
   a_cause_set: assert property ( // RULE5
      @(posedge clk_sys) disable iff (!rst_n)
      expire |=> s_q.causeWatch)
      else $error("watchdog cause not set");

   a_cause_clear: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (statusWr && !expire) |=> !s_q.causeWatch)
      else $error("cause not cleared");

   a_cause_keep: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (!statusWr && !expire) |=> $stable(s_q.causeWatch))
      else $error("cause changed alone");

   // ***********************
   // checks: register bus
   // ***********************
   a_ack_req: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      access |=> wbRsp.ack)
      else $error("request not acknowledged");

   a_ack_only: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !access |=> !wbRsp.ack)
      else $error("ack without request");

   a_ack_one: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      wbRsp.ack |=> !wbRsp.ack)
      else $error("ack longer than one cycle");

   a_clear_ack: assert property ( // RULE7
      @(posedge clk_sys) disable iff (!rst_n)
      clearWr |=> wbRsp.ack)
      else $error("clear write not acknowledged");

   a_rdat_idle: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !wbRsp.ack |-> wbRsp.dat == 8'h00)
      else $error("read data without ack");

   a_rdat_status: assert property ( // RULE5
      @(posedge clk_sys) disable iff (!rst_n)
      statusRd |=> wbRsp.dat == {7'h00, $past(s_q.causeWatch)})
      else $error("status read wrong");

   a_rdat_write: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (access && wbReq.we) |=> wbRsp.dat == 8'h00)
      else $error("read data on write");

   a_rdat_other: assert property ( // RULE7
      @(posedge clk_sys) disable iff (!rst_n)
      (access && !wbReq.we && wbReq.adr != `SRW_STATUS_ADDR) |=> wbRsp.dat == 8'h00)
      else $error("unmapped read not zero");
endmodule : srw_reset_watch

// ===== hdl/srw_cfg.svh
// Functional notes
// RULE1 - system held in reset while external reset pin is low
// RULE2 - power-on reset applied automatically when power first comes up
// RULE3 - low-voltage reset exists only when build option enables it
// RULE4 - with option on, supply below threshold asserts system reset
// RULE5 - enabled watchdog not restarted resets system after about one second
// RULE6 - firmware should restart watchdog at least every half second
// RULE7 - any write to clear port restarts watchdog count; data ignored
// RULE8 - watchdog advances only while low-frequency or prescaler clock runs
// RULE9 - any wake-up from halt or standby passes through reset
// RULE10 - all sources merge into one reset which also clears watchdog
`ifndef SRW_CFG_SVH
`define SRW_CFG_SVH
`define SRW_CLK_HZ 100000000
`define SRW_WATCH_CLEAR_ADDR 8'h7F
`define SRW_LF_HZ 32768
`define SRW_WATCH_TIMEOUT_S 1
`define SRW_WATCH_TICKS (`SRW_LF_HZ * `SRW_WATCH_TIMEOUT_S)
`define SRW_POR_CYCLES 16
`define SRW_WAKE_CYCLES 4
`define SRW_STATUS_ADDR 8'h00
`endif

// ===== hdl/srw_pkg.sv
package srw_pkg;
   typedef struct packed {
      logic [7:0] adr;
      logic [7:0] dat;
      logic we;
      logic cyc;
      logic stb;
   } srw_wb_req_t;

   typedef struct packed {
      logic [7:0] dat;
      logic ack;
   } srw_wb_rsp_t;

   typedef struct packed {
      logic [15:0] watchCnt;
      logic [4:0] porCnt;
      logic [2:0] wakeCnt;
      logic sysRst;
      logic ack;
      logic [7:0] rdat;
      logic causeWatch;
   } srw_state_t;
endpackage : srw_pkg

// ===== bench/srw_fw_model.sv
`timescale 1ns/1ps
module srw_fw_model (
   // clock
   input wire logic clk_sys,
   // control
   input wire logic kick,
   input wire logic [7:0] reqAdr,
   input wire logic reqWe,
   output logic busy,
   // read result
   output logic [7:0] rdData,
   output logic rdValid,
   // wishbone master
   output srw_pkg::srw_wb_req_t wbReq,
   input wire srw_pkg::srw_wb_rsp_t wbRsp
);
   initial begin
      wbReq = '0;
      rdData = 8'h00;
      rdValid = 1'b0;
   end
   // one request held until ack; write data random
   always @(posedge clk_sys) begin
      rdValid <= wbReq.cyc & wbRsp.ack & ~wbReq.we;
      if (wbReq.cyc && wbRsp.ack) begin
         rdData <= wbRsp.dat;
         wbReq <= '0;
      end else if (kick && !wbReq.cyc) begin
         wbReq <= '{adr: reqAdr, dat: 8'($urandom), we: reqWe,
                    cyc: 1'b1, stb: 1'b1};
      end
   end
   assign busy = wbReq.cyc;
endmodule : srw_fw_model

// ===== bench/system_reset_and_watchdog_test.sv
`timescale 1ns/1ps
`include "srw_cfg.svh"
module system_reset_and_watchdog_test;
   logic clk_sys = 0, rst_n = 0, pin_n = 1, supLow = 0, wake = 0;
   logic lf = 0, ps = 0, kick = 0, smp = 0, hit = 0, hitOff = 0, busy, sysReset, sysResetOff;
   logic reqWe = 0, rdValid;
   logic [7:0] reqAdr = 8'h00, rdData;
   srw_pkg::srw_wb_req_t wbReq;
   srw_pkg::srw_wb_rsp_t wbRsp;
   logic [1:0] expQ[$];
   logic [7:0] datQ[$];
   int n_fail = 0, cmp_count = 0, cyc = 0;
   initial forever #5 clk_sys = ~clk_sys;
   srw_reset_watch #(.WATCH_TICKS(8)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
      .extResetPin_n(pin_n), .supplyLow(supLow), .wakeEvent(wake), .lfTick(lf),
      .prescTick(ps), .wbReq(wbReq), .wbRsp(wbRsp), .sysReset(sysReset));
   // both build options off
   srw_reset_watch #(.LVR_EN(1'b0), .WATCH_EN(1'b0), .WATCH_TICKS(8)) dut_off_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .extResetPin_n(pin_n), .supplyLow(supLow),
      .wakeEvent(wake), .lfTick(lf), .prescTick(ps), .wbReq(wbReq), .wbRsp(),
      .sysReset(sysResetOff));
   srw_fw_model fw_u (.clk_sys(clk_sys), .kick(kick), .reqAdr(reqAdr), .reqWe(reqWe),
      .busy(busy), .rdData(rdData), .rdValid(rdValid), .wbReq(wbReq), .wbRsp(wbRsp));
   // ***************
   // tasks
   // ***************
   task automatic expect_rst(input logic [1:0] v);
      expQ.push_back(v);
      smp <= 1;
      @(posedge clk_sys);
      smp <= 0;
   endtask : expect_rst
   task automatic check_rst(input string name, input logic e, input logic s);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s exp %b got %b", name, e, s);
      end
   endtask : check_rst
   task automatic check_dat(input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR wbRsp.dat exp %h got %h", e, s);
      end
   endtask : check_dat
   task automatic tick(input int n);
      repeat (n) begin
         {lf, ps} <= 2'($urandom_range(1, 3));
         @(posedge clk_sys);
         {lf, ps} <= 2'h0;
         @(posedge clk_sys);
      end
   endtask : tick
   task automatic bus(input logic [7:0] a, input logic w);
      reqAdr <= a;
      reqWe <= w;
      kick <= 1;
      @(posedge clk_sys);
      kick <= 0;
      @(posedge clk_sys);
      while (busy) @(posedge clk_sys);
   endtask : bus
   task automatic read_exp(input logic [7:0] a, input logic [7:0] v);
      datQ.push_back(v);
      bus(a, 1'b0);
   endtask : read_exp
   task automatic end_of_test;
      $display("checks %0d errors %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   // reset seen since last note
   always @(negedge clk_sys) if (smp) begin
      check_rst("sysReset", expQ[0][1], hit | sysReset);
      check_rst("sysResetOff", expQ[0][0], hitOff | sysResetOff);
      void'(expQ.pop_front());
      hit = 0;
      hitOff = 0;
   end else begin
      hit = hit | sysReset;
      hitOff = hitOff | sysResetOff;
   end
   always @(negedge clk_sys) if (rdValid) check_dat(datQ.pop_front(), rdData);
   always @(posedge clk_sys) if (++cyc == 3000) begin
      n_fail++;
      end_of_test();
   end
   // ***************
   // scenarios
   // ***************
   initial begin
      void'($urandom(32'h08F038D3));
      repeat (12) @(posedge clk_sys);
      rst_n <= 1;
      repeat (20) @(posedge clk_sys);
      expect_rst(2'b11);
      tick(5);
      pin_n <= 0;
      repeat (3) @(posedge clk_sys);
      pin_n <= 1;
      expect_rst(2'b11);
      tick(7);
      expect_rst(2'b00);
      bus(`SRW_WATCH_CLEAR_ADDR, 1'b1);
      tick(7);
      expect_rst(2'b00);
      tick(1);
      expect_rst(2'b10);
      read_exp(`SRW_STATUS_ADDR, 8'h01);
      read_exp(`SRW_WATCH_CLEAR_ADDR, 8'h00);
      bus(`SRW_STATUS_ADDR, 1'b1);
      read_exp(`SRW_STATUS_ADDR, 8'h00);
      tick(7);
      expect_rst(2'b00);
      repeat (40) @(posedge clk_sys);
      expect_rst(2'b00);
      supLow <= 1;
      @(posedge clk_sys);
      supLow <= 0;
      expect_rst(2'b10);
      wake <= 1;
      @(posedge clk_sys);
      wake <= 0;
      expect_rst(2'b11);
      rst_n <= 0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1;
      repeat (20) @(posedge clk_sys);
      expect_rst(2'b11);
      expect_rst(2'b00);
      end_of_test();
   end
endmodule : system_reset_and_watchdog_test
